/* File: hw/iobci_pkg.sv */
// Package: constants, types and states for the I/O bus cycle interface
package iobci_pkg;

  // --------------------------------------------------------------------
  // Widths and timing
  // --------------------------------------------------------------------
  localparam int unsigned WORD_W          = 24;
  localparam int unsigned CHAN_W          = 4;
  localparam int unsigned CHAN_MAX        = 14;
  localparam int unsigned CHAN_LOW_TOP    = 7;
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned CA_RC_MIN_NS    = 500;
  localparam int unsigned RC_CA_MIN_CLKS  = 4;
  localparam int unsigned CLK_PERIOD_NS   = 1_000_000_000 / CLK_HZ;
  // Least time rounds up to whole cycles
  localparam int unsigned CA_RC_MIN_CLKS  =
    (CA_RC_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W           = 4;
  localparam int unsigned NUM_CYCLE_TYPES = 7;

  // --------------------------------------------------------------------
  // Command word field layout
  // --------------------------------------------------------------------
  localparam int unsigned CMD_CHAN_LSB = 16;
  localparam int unsigned CMD_TYPE_LSB = 20;
  localparam int unsigned CMD_TYPE_W   = 3;

  // Seven cycle types carried in the command word
  typedef enum logic [2:0] {
    IOBCI_XFER_OUT_A  = 3'h0,
    IOBCI_XFER_OUT_B  = 3'h1,
    IOBCI_TEST_STAT   = 3'h2,
    IOBCI_CLR_TEST    = 3'h3,
    IOBCI_TEST_SRVREQ = 3'h4,
    IOBCI_TERMINATE   = 3'h5,
    IOBCI_XFER_IN     = 3'h6
  } iobci_cyc_e;

  // Cycle sequencer states, one-hot
  typedef enum logic [3:0] {
    IOBCI_ST_IDLE    = 4'h1,
    IOBCI_ST_PHASE_A = 4'h2,
    IOBCI_ST_WAIT    = 4'h4,
    IOBCI_ST_RECOVER = 4'h8
  } iobci_state_e;

  // Microinstruction access request
  typedef struct packed {
    logic              cmd_wr;   // Move into command pseudo register
    logic              data_rd;  // Move data pseudo register to register
    logic              data_wr;  // Move register to data pseudo register
    logic [WORD_W-1:0] wdata;
  } iobci_req_s;

endpackage : iobci_pkg

/* File: hw/iobci_top.sv */
// Module: processor-side I/O bus cycle sequencer with pseudo registers
module iobci_top (
  input  wire logic                      i_clk,
  input  wire logic                      i_arst_n,
  input  wire iobci_pkg::iobci_req_s     i_req,
  input  wire logic [iobci_pkg::WORD_W-1:0] i_bus_data,
  input  wire logic                      i_service_request_line,
  output logic                           o_stall,
  output logic [iobci_pkg::WORD_W-1:0]   o_rdata,
  output logic                           o_rdata_valid,
  output logic                           o_command_active,
  output logic                           o_response_complete,
  output logic [iobci_pkg::WORD_W-1:0]   o_bus_data,
  output logic                           o_bus_data_oe,
  output logic                           o_service_pending_flag,
  output logic                           o_chan_error
);

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  iobci_pkg::iobci_state_e              state_ff, nxt_state;
  logic [iobci_pkg::CNT_W-1:0]          cnt_ff, nxt_cnt;
  logic                                 ca_ff, nxt_ca;
  logic                                 rc_ff, nxt_rc;
  logic [iobci_pkg::WORD_W-1:0]         bus_ff, nxt_bus;
  logic                                 oe_ff, nxt_oe;
  logic [iobci_pkg::WORD_W-1:0]         rdata_ff, nxt_rdata;
  logic                                 rvalid_ff, nxt_rvalid;
  logic                                 stall_ff, nxt_stall;
  logic                                 srv_ff, nxt_srv;
  logic                                 cerr_ff, nxt_cerr;
  logic [iobci_pkg::CHAN_W-1:0]         chan;
  logic                                 data_acc;

  assign chan = i_req.wdata[iobci_pkg::CMD_CHAN_LSB +: iobci_pkg::CHAN_W];
  assign data_acc = i_req.data_rd | i_req.data_wr;

  // --------------------------------------------------------------------
  // Timing of one cycle, as seen at the ports
  // --------------------------------------------------------------------
  // Edge 0: a command move is taken while idle and not stalled.
  // Edge 0 also loads the phase spacing counter with the least
  // command to response gap, less the edge that launches the pulse.
  // Cycle 1: command_active stands with the word on the exchange.
  // Cycle 1: the exchange drive is on for exactly this one cycle.
  // Edge 1: the exchange is released so the addressed control may
  // answer; a data access seen here is stalled straight away.
  // Edges 2 to 4: the counter runs down; stall stays high while more
  // than one count is left, so it falls one edge before the take.
  // Edge 5: the data access is taken and response_complete launched.
  // Cycle 6: response_complete stands; a read shows its word and
  // the valid pulse, a write drives its word for this one cycle.
  // Edges 6 to 9: the recovery gap; a command is stalled here.
  // Edge 10: the earliest edge at which a new command is taken.
  //
  // Why the stall is registered: the microengine sees a stable level
  // for a whole cycle, at the cost of one extra stall pulse after a
  // take, which the requester ignores once it has dropped its strobe.
  //
  // Hazard: a request that is dropped while stall is still high is
  // simply lost; nothing is queued, since no buffering is wanted.
  //
  // Limitation: the sequencer does not wait for the control; a
  // control that answers later than the least spacing gives stale
  // data, so every control on the bus must answer inside it.
  //
  // Limitation: cycle types are not decoded here; all seven share
  // one timing, and the type field only rides along in the word.
  //
  // Channel fifteen cannot address a control; it is flagged but the
  // cycle still runs, so the microengine never hangs on a bad word.
  //
  // A command move while a cycle is pending is not taken until the
  // cycle has ended and its recovery gap is spent.
  //
  // A data access with no cycle pending is ignored, so a stray move
  // can never launch a response pulse onto the bus.
  //
  // Trade-off: the spacing counter is shared by both gaps, since the
  // two never overlap; this saves a counter and keeps the spacing
  // checks in one place.
  //
  // The counter width covers the larger of the two gaps at the
  // nominal clock; a faster clock needs a wider counter.

  // --------------------------------------------------------------------
  // Cycle sequencer
  // --------------------------------------------------------------------
  // Requests are held by the microengine while o_stall is high; the
  // stall is registered, so a request is taken only when stall is low.
  always_comb begin
    nxt_state  = state_ff;
    nxt_cnt    = cnt_ff;
    nxt_ca     = 1'b0;
    nxt_rc     = 1'b0;
    nxt_bus    = bus_ff;
    nxt_oe     = oe_ff;
    nxt_rdata  = rdata_ff;
    nxt_rvalid = 1'b0;
    nxt_stall  = 1'b0;
    nxt_cerr   = cerr_ff;
    if (cnt_ff != '0) begin
      nxt_cnt = cnt_ff - 1'b1;
    end
    unique case (state_ff)
      iobci_pkg::IOBCI_ST_IDLE: begin
        if (i_req.cmd_wr && !stall_ff) begin
          // Command word goes onto the exchange for phase A
          nxt_state = iobci_pkg::IOBCI_ST_PHASE_A;
          nxt_ca    = 1'b1;
          nxt_bus   = i_req.wdata;
          nxt_oe    = 1'b1;
          nxt_cerr  = (chan > iobci_pkg::CHAN_MAX[iobci_pkg::CHAN_W-1:0]);
          nxt_cnt   = iobci_pkg::CNT_W'(iobci_pkg::CA_RC_MIN_CLKS - 1);
          nxt_stall = 1'b1;
        end
      end
      iobci_pkg::IOBCI_ST_PHASE_A: begin
        // Release the exchange so the control may answer
        nxt_oe    = 1'b0;
        nxt_state = iobci_pkg::IOBCI_ST_WAIT;
        nxt_stall = data_acc;
      end
      iobci_pkg::IOBCI_ST_WAIT: begin
        if (data_acc && !stall_ff && cnt_ff == '0) begin
          nxt_rc    = 1'b1;
          nxt_state = iobci_pkg::IOBCI_ST_RECOVER;
          nxt_cnt   = iobci_pkg::CNT_W'(iobci_pkg::RC_CA_MIN_CLKS);
          nxt_stall = 1'b1;
          if (i_req.data_wr) begin
            nxt_bus = i_req.wdata;
            nxt_oe  = 1'b1;
          end else begin
            nxt_rdata  = i_bus_data;
            nxt_rvalid = 1'b1;
          end
        end else if (data_acc && cnt_ff > 1) begin
          nxt_stall = 1'b1;
        end
      end
      iobci_pkg::IOBCI_ST_RECOVER: begin
        nxt_oe = 1'b0;
        // Hold off a new command until the recovery gap is spent
        nxt_stall = i_req.cmd_wr && (cnt_ff > 1);
        if (cnt_ff <= 1) begin
          nxt_state = iobci_pkg::IOBCI_ST_IDLE;
        end
      end
      default: begin
        nxt_state = iobci_pkg::IOBCI_ST_IDLE;
        nxt_oe    = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_ff  <= iobci_pkg::IOBCI_ST_IDLE;
      cnt_ff    <= '0;
      ca_ff     <= 1'b0;
      rc_ff     <= 1'b0;
      bus_ff    <= '0;
      oe_ff     <= 1'b0;
      rdata_ff  <= '0;
      rvalid_ff <= 1'b0;
      stall_ff  <= 1'b0;
      cerr_ff   <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      cnt_ff    <= nxt_cnt;
      ca_ff     <= nxt_ca;
      rc_ff     <= nxt_rc;
      bus_ff    <= nxt_bus;
      oe_ff     <= nxt_oe;
      rdata_ff  <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
      stall_ff  <= nxt_stall;
      cerr_ff   <= nxt_cerr;
    end
  end

  // --------------------------------------------------------------------
  // Service pending condition bit
  // --------------------------------------------------------------------
  // Level mirror; one clock of latency, no latching needed
  always_comb begin
    nxt_srv = i_service_request_line;
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      srv_ff <= 1'b0;
    end else begin
      srv_ff <= nxt_srv;
    end
  end

  assign o_stall                = stall_ff;
  assign o_rdata                = rdata_ff;
  assign o_rdata_valid          = rvalid_ff;
  assign o_command_active       = ca_ff;
  assign o_response_complete    = rc_ff;
  assign o_bus_data             = bus_ff;
  assign o_bus_data_oe          = oe_ff;
  assign o_service_pending_flag = srv_ff;
  assign o_chan_error           = cerr_ff;

endmodule : iobci_top

/* File: dv/iobci_sva.sv */
// Checker: timing and data relations at the I/O bus cycle ports
module iobci_sva (
  input wire logic                  i_clk,
  input wire logic                  i_arst_n,
  input wire iobci_pkg::iobci_req_s i_req,
  input wire logic [23:0]           i_bus_data,
  input wire logic                  i_service_request_line,
  input wire logic [23:0]           o_rdata,
  input wire logic                  o_rdata_valid,
  input wire logic                  o_command_active,
  input wire logic                  o_response_complete,
  input wire logic [23:0]           o_bus_data,
  input wire logic                  o_bus_data_oe,
  input wire logic                  o_service_pending_flag,
  input wire logic                  o_chan_error
);
  default clocking dc @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  // Phase pulses, spacing and what each phase carries
  ca_one_cycle_a: assert property (o_command_active |=> !o_command_active)
    else $error("command active held too long");
  rc_one_cycle_a: assert property (o_response_complete |=> !o_response_complete)
    else $error("response complete held too long");
  ca_rc_gap_a: assert property ($rose(o_command_active) |=> !o_response_complete [*4])
    else $error("response came too soon after command");
  rc_ca_gap_a: assert property (o_response_complete |=> !o_command_active [*4])
    else $error("command came too soon after response");
  cmd_drive_a: assert property (o_command_active |-> o_bus_data_oe &&
    o_bus_data == $past(i_req.wdata)) else $error("command word not driven");
  rc_cause_a: assert property (o_response_complete |->
    $past(i_req.data_rd || i_req.data_wr)) else $error("response without access");
  read_data_a: assert property (o_rdata_valid |-> o_response_complete &&
    o_rdata == $past(i_bus_data)) else $error("read data mismatch");
  srv_mirror_a: assert property (!$past(i_arst_n) ||
    o_service_pending_flag == $past(i_service_request_line)) else $error("flag lost");
  chan_flag_a: assert property (o_command_active |=>
    o_chan_error == ($past(i_req.wdata[19:16], 2) > 4'hE)) else $error("bad chan flag");
endmodule : iobci_sva

bind iobci_top iobci_sva iobci_sva_inst (.*);

/* File: dv/iobci_ctl_model.sv */
// Model of an I/O control answering a command on the exchange lines
module iobci_ctl_model (
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_ca,
  input  wire logic        i_rc,
  input  wire logic [23:0] i_cmd,
  input  wire logic        i_slow,
  output logic      [23:0] o_resp
);
  logic [23:0] resp;
  logic [1:0]  wait_cnt;
  logic        busy;
  // Released lines toggle so a stale word never passes for an answer
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      busy     <= 1'b0;
      wait_cnt <= 2'h0;
      o_resp   <= 24'h5A5A5A;
    end else begin
      if (i_ca && i_cmd[19:16] != 4'hF) begin
        busy     <= 1'b1;
        // A slow control still answers inside the least phase spacing
        wait_cnt <= i_slow ? 2'h2 : 2'h0;
        resp     <= {i_cmd[7:0], i_cmd[23:8]};
      end else if (i_rc) busy <= 1'b0;
      else if (wait_cnt != 2'h0) wait_cnt <= wait_cnt - 2'h1;
      o_resp <= (busy && wait_cnt == 2'h0) ? resp : ~o_resp;
    end
  end
endmodule : iobci_ctl_model

/* File: dv/tb.sv */
// Testbench: I/O bus cycles driven as microinstruction accesses
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                  i_clk, i_arst_n, i_service_request_line, slow;
  iobci_pkg::iobci_req_s i_req;
  logic [23:0]           i_bus_data, o_rdata, o_bus_data;
  logic                  o_stall, o_rdata_valid, o_command_active;
  logic                  o_response_complete, o_bus_data_oe;
  logic                  o_service_pending_flag, o_chan_error;
  int                    failures = 0, n_checks = 0, cyc = 0, last_rc = 0;
  iobci_top iobci_top_inst (.*);
  iobci_ctl_model iobci_ctl_model_inst (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_ca(o_command_active), .i_rc(o_response_complete), .i_cmd(o_bus_data),
    .i_slow(slow), .o_resp(i_bus_data));
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  always @(posedge i_clk) cyc <= cyc + 1;
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run;
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  // Command then an early data access, which must be held off
  task automatic io_cycle(input logic [23:0] w, d, input logic rd);
    int n;
    @(negedge i_clk);
    i_req = '{1'b1, 1'b0, 1'b0, w};
    repeat (40) if (!o_command_active) @(negedge i_clk);
    check(o_bus_data, w);
    check(o_command_active, 1'b1);
    if (last_rc > 0) check(cyc - last_rc >= 5, 1'b1);
    n = cyc;
    i_req = '{1'b0, rd, !rd, d};
    repeat (2) @(negedge i_clk);
    check(o_stall, 1'b1);
    repeat (40) if (!o_response_complete) @(negedge i_clk);
    check(o_response_complete, 1'b1);
    check(cyc - n >= 5, 1'b1);
    check(o_rdata_valid, rd);
    if (rd && w[19:16] != 4'hF) check(o_rdata, {w[7:0], w[23:8]});
    if (!rd) check(o_bus_data, d);
    check(o_chan_error, w[19:16] == 4'hF);
    last_rc = cyc;
    i_req = '0;
  endtask : io_cycle
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_types;
    for (int t = 0; t < 7; t++) begin
      slow = t[0];
      io_cycle({1'b0, t[2:0], t[3:0], 16'h3C5A ^ 16'(t)}, 24'h0, 1'b1);
    end
  endtask : t_types
  task automatic t_write_and_chans;
    io_cycle(24'h1C5A3C, 24'hC30F96, 1'b0);
    io_cycle(24'h67A1B2, 24'h0, 1'b1);
    io_cycle(24'h28C3D4, 24'h0, 1'b1);
    io_cycle(24'h4E9687, 24'h0, 1'b1);
    io_cycle(24'h5F1234, 24'h0, 1'b1);
  endtask : t_write_and_chans
  task automatic t_service;
    @(negedge i_clk);
    i_service_request_line = 1'b1;
    repeat (2) @(negedge i_clk);
    check(o_service_pending_flag, 1'b1);
    i_service_request_line = 1'b0;
    repeat (2) @(negedge i_clk);
    check(o_service_pending_flag, 1'b0);
  endtask : t_service
  // A data access with no cycle pending must not close anything
  task automatic t_stray;
    i_req = '{1'b0, 1'b1, 1'b0, 24'h0};
    repeat (8) begin
      @(negedge i_clk);
      check(o_response_complete, 1'b0);
    end
    i_req = '0;
  endtask : t_stray
  initial begin
    i_arst_n = 1'b0;
    i_req = '0;
    i_service_request_line = 1'b0;
    slow = 1'b0;
    repeat (2) @(negedge i_clk);
    i_arst_n = 1'b1;
    t_stray();
    t_types();
    t_write_and_chans();
    t_service();
    complete_run();
  end
  // Full run needs about 130 cycles; cut a hang well past that
  initial begin
    #400_000;
    failures++;
    complete_run();
  end
endmodule : tb
